// ==== hw/fpe_pkg.sv ====
/*
 * Shared constants for the flash program/erase sequencer: wait times,
 * iteration caps, control-bit positions, register map and FSM states.
 * Assumes a single 100 MHz core clock; all waits but the RD_WAIT_CYC
 * read wait are counted in microsecond ticks derived from that clock.
 */
package fpe_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_US     = 1000;
   localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
   localparam int US_PER_MS     = 1000;

   // Program waits, microseconds, and round cap
   localparam int T_SWE_US      = 10;
   localparam int T_PSU_US      = 50;
   localparam int T_P_MAX_US    = 200;
   localparam int T_P_OFF_US    = 10;
   localparam int T_PSU_OFF_US  = 10;
   localparam int T_PV_US       = 4;
   localparam int T_DUMMY_US    = 2;
   localparam int T_PV_OFF_US   = 4;
   localparam int N_PROG_MAX    = 1000;

   // Erase waits, microseconds unless named otherwise, and round cap
   localparam int T_ESU_US      = 200;
   localparam int T_E_MAX_MS    = 5;
   localparam int T_E_MAX_US    = T_E_MAX_MS * US_PER_MS;
   localparam int T_E_OFF_US    = 10;
   localparam int T_ESU_OFF_US  = 10;
   localparam int T_EV_US       = 20;
   localparam int T_EV_OFF_US   = 5;
   localparam int N_ERASE_MAX   = 60;

   // Sizes and data
   localparam int UNIT_BYTES    = 32;
   localparam int IW            = $clog2(UNIT_BYTES);
   localparam int TW            = 13;
   localparam int IT_W          = 10;
   localparam int RD_WAIT_CYC   = 4;
   localparam logic [7:0] DUMMY_DATA  = 8'hFF;
   localparam logic [7:0] ERASED_DATA = 8'hFF;

   // Positions of the flash control bits in the driven vector
   localparam logic [2:0] B_SWE = 3'h0;
   localparam logic [2:0] B_PSU = 3'h1;
   localparam logic [2:0] B_P   = 3'h2;
   localparam logic [2:0] B_PV  = 3'h3;
   localparam logic [2:0] B_ESU = 3'h4;
   localparam logic [2:0] B_E   = 3'h5;
   localparam logic [2:0] B_EV  = 3'h6;

   // Register map, byte addresses
   localparam logic [7:0] O_CTRL    = 8'h00;
   localparam logic [7:0] O_STATUS  = 8'h04;
   localparam logic [7:0] O_ADDR    = 8'h08;
   localparam logic [7:0] O_PTIME   = 8'h0C;
   localparam logic [7:0] O_ETIME   = 8'h10;
   localparam logic [7:0] O_VCNT    = 8'h14;
   localparam logic [7:0] DATA_BASE = 8'h20;
   localparam logic [7:0] DATA_MASK = 8'hE0;

   // Fields
   localparam int CT_GO_PROG   = 0;
   localparam int CT_GO_ERASE  = 1;
   localparam int ST_BUSY      = 0;
   localparam int ST_PASS      = 1;
   localparam int ST_FAIL      = 2;
   localparam int ST_ERASE     = 3;
   localparam int ST_ITER_LSB  = 16;
   localparam logic [15:0] R_VCNT = 16'h0400;

   typedef enum logic [3:0] {
      S_IDLE, S_SWE, S_LOAD, S_SU, S_PULSE, S_PULSE_OFF,
      S_SU_OFF, S_VFY, S_DUMMY, S_READ, S_VFY_OFF
   } fpe_state_t;
endpackage : fpe_pkg

// ==== hw/fpe_seq.sv ====
/*
 * Flash program/erase sequencer that drives the flash control bits,
 * writes the 32-byte unit, issues the dummy write and verify reads.
 * Assumes the flash answers a read within two clocks and holds the
 * data until the next read; rdata arrives asynchronously.
 */
// What this block does
// RQ1 - After setting write enable, wait at least 10 us before the next step.
// RQ2 - After setting program setup, wait at least 50 us before the pulse.
// RQ3 - Keep each program pulse at most 200 us long.
// RQ4 - After clearing program pulse, wait 10 us before clearing setup.
// RQ5 - After clearing program setup, wait 10 us before setting verify.
// RQ6 - After setting program verify, wait 4 us before the dummy write.
// RQ7 - Dummy write of FF, then 2 us before any verify read.
// RQ8 - After clearing program verify, wait 4 us before continuing.
// RQ9 - Program fails after 1000 pulse and verify rounds without pass.
// RQ10 - After setting erase setup, wait at least 200 us before the pulse.
// RQ11 - Keep each erase pulse at most 5 ms long.
// RQ12 - After clearing erase pulse, wait 10 us before clearing setup.
// RQ13 - After clearing erase setup, wait 10 us before setting verify.
// RQ14 - After setting erase verify, wait 20 us before the dummy write.
// RQ15 - After clearing erase verify, wait 5 us before continuing.
// RQ16 - Erase fails after 60 pulse and verify rounds without pass.
// RQ17 - Program works on 32-byte units, erase on whole blocks.
// RQ18 - Order: enable, setup, pulse, clear pulse, clear setup, verify, clear.
`timescale 1ns/1ns
module fpe_seq #(
   parameter int CYC_PER_US = fpe_pkg::CYC_PER_US,
   parameter int PSU_US     = fpe_pkg::T_PSU_US,
   parameter int P_MAX_US   = fpe_pkg::T_P_MAX_US,
   parameter int ESU_US     = fpe_pkg::T_ESU_US,
   parameter int E_MAX_US   = fpe_pkg::T_E_MAX_US,
   parameter int N_PROG     = fpe_pkg::N_PROG_MAX,
   parameter int N_ERASE    = fpe_pkg::N_ERASE_MAX
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [7:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [31:0]  reg_rdata,
   output logic              flash_write_enable_bit,
   output logic              program_setup_bit,
   output logic              program_pulse_bit,
   output logic              program_verify_bit,
   output logic              erase_setup_bit,
   output logic              erase_pulse_bit,
   output logic              erase_verify_bit,
   output logic              flash_wr,
   output logic              flash_rd,
   output logic      [15:0]  flash_addr,
   output logic      [7:0]   flash_wdata,
   input  wire logic [7:0]   flash_rdata
);
   localparam int TW   = fpe_pkg::TW;
   localparam int IW   = fpe_pkg::IW;
   localparam int IT_W = fpe_pkg::IT_W;
   localparam logic [TW-1:0] U_SWE    = TW'(fpe_pkg::T_SWE_US);
   localparam logic [TW-1:0] U_PSU    = TW'(PSU_US);
   localparam logic [TW-1:0] U_ESU    = TW'(ESU_US);
   localparam logic [TW-1:0] U_P_OFF  = TW'(fpe_pkg::T_P_OFF_US);
   localparam logic [TW-1:0] U_E_OFF  = TW'(fpe_pkg::T_E_OFF_US);
   localparam logic [TW-1:0] U_PS_OFF = TW'(fpe_pkg::T_PSU_OFF_US);
   localparam logic [TW-1:0] U_ES_OFF = TW'(fpe_pkg::T_ESU_OFF_US);
   localparam logic [TW-1:0] U_PV     = TW'(fpe_pkg::T_PV_US);
   localparam logic [TW-1:0] U_EV     = TW'(fpe_pkg::T_EV_US);
   localparam logic [TW-1:0] U_DUMMY  = TW'(fpe_pkg::T_DUMMY_US);
   localparam logic [TW-1:0] U_PV_OFF = TW'(fpe_pkg::T_PV_OFF_US);
   localparam logic [TW-1:0] U_EV_OFF = TW'(fpe_pkg::T_EV_OFF_US);
   localparam logic [IT_W-1:0] IT_PROG  = IT_W'(N_PROG);
   localparam logic [IT_W-1:0] IT_ERASE = IT_W'(N_ERASE);
   localparam logic [1:0] RW_LAST = 2'(fpe_pkg::RD_WAIT_CYC - 1);

   if (P_MAX_US < 2 || P_MAX_US > 256 || E_MAX_US < 2 || E_MAX_US >= 2**TW ||
       ESU_US >= 2**TW || N_PROG >= 2**IT_W || N_ERASE >= 2**IT_W ||
       N_PROG < 1 || N_ERASE < 1) begin : g_chk
      $error("fpe_seq: parameter out of range");
   end

   fpe_tmr_if tif ();
   fpe_us_tick #(.CYC(CYC_PER_US)) u_tick (
      .core_clk (core_clk),
      .rst      (rst),
      .t        (tif.pre)
   );
   fpe_wait_timer u_tmr (
      .core_clk (core_clk),
      .rst      (rst),
      .t        (tif.tmr)
   );

   fpe_pkg::fpe_state_t st_q, st_d;
   logic [6:0]      bits_q, bits_d;
   logic            ers_q, ers_d, ld_q, ld_d, ok_q, ok_d, pass_q, pass_d, fail_q, fail_d;
   logic            fwr_q, fwr_d, frd_q, frd_d;
   logic [TW-1:0]   us_q, us_d;
   logic [15:0]     fadr_q, fadr_d, idx_q, idx_d, base_q, vcnt_q;
   logic [7:0]      fdat_q, fdat_d, ptime_q, rsa_q, rsb_q;
   logic [TW-1:0]   etime_q;
   logic [IT_W-1:0] iter_q, iter_d;
   logic [1:0]      rw_q, rw_d;
   logic [31:0]     rdata_q;
   logic [7:0]      buf_q [fpe_pkg::UNIT_BYTES];

   // Register decode
   logic        hit_data, wr_ctrl, go_p, go_e, idle;
   logic [2:0]  widx;
   logic [31:0] data_word, status_w, rd_mux;
   assign idle     = (st_q == fpe_pkg::S_IDLE);
   assign hit_data = (reg_addr & fpe_pkg::DATA_MASK) == fpe_pkg::DATA_BASE;
   assign widx     = reg_addr[4:2];
   assign wr_ctrl  = reg_wr && reg_addr == fpe_pkg::O_CTRL && idle;
   // Program wins if both start bits are written together
   assign go_p     = wr_ctrl && reg_wdata[fpe_pkg::CT_GO_PROG];
   assign go_e     = wr_ctrl && reg_wdata[fpe_pkg::CT_GO_ERASE] && !go_p;
   assign data_word = {buf_q[{widx, 2'd3}], buf_q[{widx, 2'd2}],
                       buf_q[{widx, 2'd1}], buf_q[{widx, 2'd0}]};
   assign status_w = {6'h00, iter_q, 12'h000, ers_q, fail_q, pass_q, !idle};
   assign rd_mux = hit_data ? data_word :
                   reg_addr == fpe_pkg::O_STATUS ? status_w :
                   reg_addr == fpe_pkg::O_ADDR   ? {16'h0000, base_q} :
                   reg_addr == fpe_pkg::O_PTIME  ? {24'h00_0000, ptime_q} :
                   reg_addr == fpe_pkg::O_ETIME  ? {19'h0_0000, etime_q} :
                   reg_addr == fpe_pkg::O_VCNT   ? {16'h0000, vcnt_q} : 32'h0000_0000;

   // Software registers; unit data is only written while idle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         base_q  <= 16'h0000;
         ptime_q <= 8'(P_MAX_US - 1);
         etime_q <= TW'(E_MAX_US - 1);
         vcnt_q  <= fpe_pkg::R_VCNT;
         rdata_q <= 32'h0000_0000;
         for (int i = 0; i < fpe_pkg::UNIT_BYTES; i++) buf_q[i] <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
         if (reg_wr && idle) begin
            if (reg_addr == fpe_pkg::O_ADDR)  base_q  <= reg_wdata[15:0];
            if (reg_addr == fpe_pkg::O_PTIME) ptime_q <= reg_wdata[7:0];
            if (reg_addr == fpe_pkg::O_ETIME) etime_q <= reg_wdata[TW-1:0];
            if (reg_addr == fpe_pkg::O_VCNT)  vcnt_q  <= reg_wdata[15:0];
            if (hit_data) begin
               for (int k = 0; k < 4; k++) buf_q[{widx, 2'(k)}] <= reg_wdata[8*k +: 8];
            end
         end
      end
   end

   // Verify data from the flash pins, two stages before use
   always_ff @(posedge core_clk) begin
      rsa_q <= flash_rdata;
      rsb_q <= rsa_q;
   end

   // Pulse lengths clamped one microsecond short of the maximum,
   // since the bit stays up two clocks beyond the timed wait
   logic [TW-1:0] p_us, e_us, pulse_us, vfy_us, voff_us;
   logic [2:0]    su_i, pl_i, vf_i;
   logic [7:0]    expect_b;
   logic [15:0]   lim;
   logic          match, last_rd, tdone;
   assign p_us = ptime_q == 8'h00 ? TW'(1) :
                 ptime_q >= 8'(P_MAX_US - 1) ? TW'(P_MAX_US - 1) : TW'(ptime_q);
   assign e_us = etime_q == '0 ? TW'(1) :
                 etime_q >= TW'(E_MAX_US - 1) ? TW'(E_MAX_US - 1) : etime_q;
   assign pulse_us = ers_q ? e_us : p_us;
   assign vfy_us   = ers_q ? U_EV : U_PV;
   assign voff_us  = ers_q ? U_EV_OFF : U_PV_OFF;
   assign su_i     = ers_q ? fpe_pkg::B_ESU : fpe_pkg::B_PSU;
   assign pl_i     = ers_q ? fpe_pkg::B_E : fpe_pkg::B_P;
   assign vf_i     = ers_q ? fpe_pkg::B_EV : fpe_pkg::B_PV;
   assign expect_b = ers_q ? fpe_pkg::ERASED_DATA : buf_q[idx_q[IW-1:0]];
   assign match    = rsb_q == expect_b;
   // RQ17 unit or block
   assign lim      = ers_q ? vcnt_q : 16'(fpe_pkg::UNIT_BYTES);
   assign last_rd  = (17'(idx_q) + 17'd1) >= 17'(lim);
   assign tdone    = tif.done;
   assign tif.load = ld_q;
   assign tif.us   = us_q;

   // RQ18 step order
   always_comb begin
      st_d = st_q;  bits_d = bits_q; ers_d = ers_q; ld_d = 1'b0; us_d = us_q;
      fwr_d = 1'b0; frd_d = 1'b0; fadr_d = fadr_q; fdat_d = fdat_q; idx_d = idx_q;
      iter_d = iter_q; ok_d = ok_q; pass_d = pass_q; fail_d = fail_q; rw_d = rw_q;
      unique case (st_q)
         fpe_pkg::S_IDLE: if (go_p || go_e) begin
            ers_d = go_e; bits_d[fpe_pkg::B_SWE] = 1'b1; ld_d = 1'b1; us_d = U_SWE;
            iter_d = '0; pass_d = 1'b0; fail_d = 1'b0; st_d = fpe_pkg::S_SWE;
         end
         // RQ1 enable settle
         fpe_pkg::S_SWE: if (tdone) begin
            if (ers_q) begin
               bits_d[su_i] = 1'b1; ld_d = 1'b1; us_d = U_ESU; st_d = fpe_pkg::S_SU;
            end else begin
               idx_d = 16'h0000; st_d = fpe_pkg::S_LOAD;
            end
         end
         // RQ17 unit fill
         fpe_pkg::S_LOAD: begin
            fwr_d = 1'b1; fadr_d = 16'(base_q + idx_q); fdat_d = buf_q[idx_q[IW-1:0]];
            idx_d = idx_q + 16'h0001;
            if (last_rd) begin
               bits_d[su_i] = 1'b1; ld_d = 1'b1; us_d = U_PSU; st_d = fpe_pkg::S_SU;
            end
         end
         // RQ2 RQ10 setup settle
         fpe_pkg::S_SU: if (tdone) begin
            bits_d[pl_i] = 1'b1; ld_d = 1'b1; us_d = pulse_us;
            iter_d = iter_q + 1'b1; st_d = fpe_pkg::S_PULSE;
         end
         // RQ3 RQ11 timed pulse
         fpe_pkg::S_PULSE: if (tdone) begin
            bits_d[pl_i] = 1'b0; ld_d = 1'b1; us_d = ers_q ? U_E_OFF : U_P_OFF;
            st_d = fpe_pkg::S_PULSE_OFF;
         end
         // RQ4 RQ12 pulse off
         fpe_pkg::S_PULSE_OFF: if (tdone) begin
            bits_d[su_i] = 1'b0; ld_d = 1'b1; us_d = ers_q ? U_ES_OFF : U_PS_OFF;
            st_d = fpe_pkg::S_SU_OFF;
         end
         // RQ5 RQ13 setup off
         fpe_pkg::S_SU_OFF: if (tdone) begin
            bits_d[vf_i] = 1'b1; ld_d = 1'b1; us_d = vfy_us; st_d = fpe_pkg::S_VFY;
         end
         // RQ6 RQ14 dummy write
         fpe_pkg::S_VFY: if (tdone) begin
            fwr_d = 1'b1; fadr_d = base_q; fdat_d = fpe_pkg::DUMMY_DATA;
            ld_d = 1'b1; us_d = U_DUMMY; st_d = fpe_pkg::S_DUMMY;
         end
         // RQ7 dummy settle
         fpe_pkg::S_DUMMY: if (tdone) begin
            idx_d = 16'h0000; ok_d = 1'b1; rw_d = 2'd0; frd_d = 1'b1; fadr_d = base_q;
            st_d = fpe_pkg::S_READ;
         end
         fpe_pkg::S_READ: if (rw_q == RW_LAST) begin
            ok_d = ok_q && match;
            if (last_rd) begin
               bits_d[vf_i] = 1'b0; ld_d = 1'b1; us_d = voff_us; st_d = fpe_pkg::S_VFY_OFF;
            end else begin
               idx_d = idx_q + 16'h0001; frd_d = 1'b1; rw_d = 2'd0;
               fadr_d = 16'(base_q + idx_q + 16'h0001);
            end
         end else begin
            rw_d = rw_q + 2'd1;
         end
         // RQ8 RQ15 verify off, RQ9 RQ16 round cap
         fpe_pkg::S_VFY_OFF: if (tdone) begin
            if (ok_q || iter_q >= (ers_q ? IT_ERASE : IT_PROG)) begin
               bits_d[fpe_pkg::B_SWE] = 1'b0; pass_d = ok_q; fail_d = !ok_q;
               st_d = fpe_pkg::S_IDLE;
            end else if (ers_q) begin
               bits_d[su_i] = 1'b1; ld_d = 1'b1; us_d = U_ESU; st_d = fpe_pkg::S_SU;
            end else begin
               idx_d = 16'h0000; st_d = fpe_pkg::S_LOAD;
            end
         end
      endcase
   end

   // Sequencer state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= fpe_pkg::S_IDLE; bits_q <= 7'h00; ers_q <= 1'b0; ld_q <= 1'b0;
         us_q <= '0; fwr_q <= 1'b0; frd_q <= 1'b0; fadr_q <= 16'h0000;
         fdat_q <= 8'h00; idx_q <= 16'h0000; iter_q <= '0; ok_q <= 1'b0;
         pass_q <= 1'b0; fail_q <= 1'b0; rw_q <= 2'd0;
      end else begin
         st_q <= st_d; bits_q <= bits_d; ers_q <= ers_d; ld_q <= ld_d;
         us_q <= us_d; fwr_q <= fwr_d; frd_q <= frd_d; fadr_q <= fadr_d;
         fdat_q <= fdat_d; idx_q <= idx_d; iter_q <= iter_d; ok_q <= ok_d;
         pass_q <= pass_d; fail_q <= fail_d; rw_q <= rw_d;
      end
   end

   assign reg_rdata              = rdata_q;
   assign flash_write_enable_bit = bits_q[fpe_pkg::B_SWE];
   assign program_setup_bit      = bits_q[fpe_pkg::B_PSU];
   assign program_pulse_bit      = bits_q[fpe_pkg::B_P];
   assign program_verify_bit     = bits_q[fpe_pkg::B_PV];
   assign erase_setup_bit        = bits_q[fpe_pkg::B_ESU];
   assign erase_pulse_bit        = bits_q[fpe_pkg::B_E];
   assign erase_verify_bit       = bits_q[fpe_pkg::B_EV];
   assign flash_wr               = fwr_q;
   assign flash_rd               = frd_q;
   assign flash_addr             = fadr_q;
   assign flash_wdata            = fdat_q;

   // Checking helpers: cycles since the last control-bit change and write
   logic        chg;
   logic [6:0]  old_q;
   logic [23:0] age_q, wage_q;
   assign chg = bits_d != bits_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         age_q <= 24'h00_0000; wage_q <= 24'h00_0000; old_q <= 7'h00;
      end else begin
         age_q  <= chg ? 24'h00_0000 : age_q + 24'(!(&age_q));
         wage_q <= fwr_q ? 24'h00_0000 : wage_q + 24'(!(&wage_q));
         if (chg) old_q <= bits_q;
      end
   end
   localparam int C_SWE = fpe_pkg::T_SWE_US * CYC_PER_US;
   localparam int C_PSU = PSU_US * CYC_PER_US;
   localparam int C_ESU = ESU_US * CYC_PER_US;
   localparam int C_PMX = P_MAX_US * CYC_PER_US;
   localparam int C_EMX = E_MAX_US * CYC_PER_US;
   localparam int C_10  = fpe_pkg::T_P_OFF_US * CYC_PER_US;
   localparam int C_PV  = fpe_pkg::T_PV_US * CYC_PER_US;
   localparam int C_EV  = fpe_pkg::T_EV_US * CYC_PER_US;
   localparam int C_DUM = fpe_pkg::T_DUMMY_US * CYC_PER_US;
   localparam int C_PVO = fpe_pkg::T_PV_OFF_US * CYC_PER_US;
   localparam int C_EVO = fpe_pkg::T_EV_OFF_US * CYC_PER_US;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_swe_settle: assert property (chg && bits_q[0] && !old_q[0] |-> age_q >= C_SWE) // RQ1
      else $error("step too soon after write enable");
   a_psu_settle: assert property (chg && bits_d[2] && !bits_q[2] |-> age_q >= C_PSU) // RQ2
      else $error("program pulse too soon after setup");
   a_ppulse_max: assert property (bits_q[2] |-> age_q < C_PMX) // RQ3
      else $error("program pulse too long");
   a_poff_wait: assert property (chg && bits_q[1] && !bits_d[1] |-> age_q >= C_10) // RQ4
      else $error("program setup cleared too soon");
   a_pv_gap: assert property (chg && bits_d[3] && !bits_q[3] |-> age_q >= C_10) // RQ5
      else $error("program verify set too soon");
   a_pv_dummy: assert property (fwr_q && bits_q[3] |-> // RQ6
      age_q >= C_PV && fdat_q == fpe_pkg::DUMMY_DATA)
      else $error("program dummy write early or wrong");
   a_dummy_read: assert property (frd_q |-> wage_q >= C_DUM && $past(fwr_q, 1) == 1'b0) // RQ7
      else $error("verify read too soon after dummy write");
   a_pvoff_wait: assert property (chg && old_q[3] && !bits_q[3] |-> age_q >= C_PVO) // RQ8
      else $error("step too soon after program verify clear");
   a_prog_cap: assert property (!ers_q |-> iter_q <= IT_PROG) // RQ9
      else $error("program rounds over cap");
   a_esu_settle: assert property (chg && bits_d[5] && !bits_q[5] |-> age_q >= C_ESU) // RQ10
      else $error("erase pulse too soon after setup");
   a_epulse_max: assert property (bits_q[5] |-> age_q < C_EMX) // RQ11
      else $error("erase pulse too long");
   a_eoff_wait: assert property (chg && bits_q[4] && !bits_d[4] |-> age_q >= C_10) // RQ12
      else $error("erase setup cleared too soon");
   a_ev_gap: assert property (chg && bits_d[6] && !bits_q[6] |-> age_q >= C_10) // RQ13
      else $error("erase verify set too soon");
   a_ev_dummy: assert property (fwr_q && bits_q[6] |-> // RQ14
      age_q >= C_EV && fdat_q == fpe_pkg::DUMMY_DATA)
      else $error("erase dummy write early or wrong");
   a_evoff_wait: assert property (chg && old_q[6] && !bits_q[6] |-> age_q >= C_EVO) // RQ15
      else $error("step too soon after erase verify clear");
   a_erase_cap: assert property (ers_q |-> iter_q <= IT_ERASE) // RQ16
      else $error("erase rounds over cap");
   // Setup rises on the same edge that launches the last unit write
   a_unit_size: assert property ($rose(bits_q[1]) |-> // RQ17
      fadr_q == 16'(base_q + 16'(fpe_pkg::UNIT_BYTES - 1)))
      else $error("program unit not 32 bytes");
   c_prog_pass: cover property (!ers_q && $rose(pass_q));
   c_erase_pass: cover property (ers_q && $rose(pass_q));
   c_fail: cover property ($rose(fail_q));
   c_retry: cover property (iter_q == 2 && bits_q[2]);
endmodule : fpe_seq

// ==== hw/fpe_tmr_if.sv ====
/*
 * Carrier between the sequencer, its microsecond prescaler and its
 * wait timer. Assumes all three sit on the same core clock.
 */
`timescale 1ns/1ns
interface fpe_tmr_if;
   logic                    load;
   logic [fpe_pkg::TW-1:0]  us;
   logic                    tick;
   logic                    done;
   modport ctl (output load, output us, input tick, input done);
   modport tmr (input load, input us, input tick, output done);
   modport pre (input load, output tick);
endinterface : fpe_tmr_if

// ==== hw/fpe_us_tick.sv ====
/*
 * Microsecond prescaler: a one-cycle enable every CYC clocks.
 * Assumes load restarts it so a wait starts on a clean tick phase.
 */
`timescale 1ns/1ns
module fpe_us_tick #(
   parameter int CYC = fpe_pkg::CYC_PER_US
) (
   input wire logic  core_clk,
   input wire logic  rst,
   fpe_tmr_if.pre    t
);
   logic [15:0] pre_q;

   if (CYC < 1 || CYC > 65536) begin : g_chk
      $error("fpe_us_tick: CYC out of range");
   end

   // Restart on load, so a wait of N ticks is never shorter than N us
   assign t.tick = (pre_q == 16'(CYC - 1));

   always_ff @(posedge core_clk) begin
      if (rst || t.load || t.tick) begin
         pre_q <= 16'h0000;
      end else begin
         pre_q <= pre_q + 16'h0001;
      end
   end
endmodule : fpe_us_tick

// ==== hw/fpe_wait_timer.sv ====
/*
 * Down-counter of microsecond ticks. Done is low while loading, so a
 * stale done from the previous wait cannot be seen.
 * Assumes load is a one-cycle pulse from the sequencer.
 */
`timescale 1ns/1ns
module fpe_wait_timer (
   input wire logic  core_clk,
   input wire logic  rst,
   fpe_tmr_if.tmr    t
);
   logic [fpe_pkg::TW-1:0] cnt_q;

   assign t.done = (cnt_q == '0) && !t.load;

   // Count down one per tick, hold at zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (t.load) begin
         cnt_q <= t.us;
      end else if (t.tick && cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule : fpe_wait_timer

// ==== verif/fpe_flash_model.sv ====
/*
 * Behavioural flash array facing the sequencer: byte writes and reads,
 * whole-array erase while the erase pulse is up.
 * Assumes one core clock and one byte per access.
 */
`timescale 1ns/1ns
module fpe_flash_model (
   input  wire logic        core_clk,
   input  wire logic        bad,
   input  wire logic        ver,
   input  wire logic        erase,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata
);
   logic [7:0] mem [256];
   initial rdata = 8'h00;
   // Inverted read data when bad, so verify never passes
   always @(posedge core_clk) begin
      if (erase) foreach (mem[i]) mem[i] <= 8'hFF;
      if (wr && !ver) mem[addr[7:0]] <= wdata;
      if (rd) rdata <= bad ? ~mem[addr[7:0]] : mem[addr[7:0]];
   end
endmodule : fpe_flash_model

// ==== verif/tb_top.sv ====
/*
 * Self-checking bench for the sequencer with shortened waits.
 * Assumes the flash model answers every read on the next clock.
 */
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
   logic        core_clk, rst, reg_wr, reg_rd, bad, flash_wr, flash_rd;
   logic        flash_write_enable_bit, program_setup_bit, program_pulse_bit;
   logic        program_verify_bit, erase_setup_bit, erase_pulse_bit, erase_verify_bit;
   logic [7:0]  reg_addr, flash_wdata, flash_rdata, exp_q [32];
   logic [15:0] flash_addr;
   logic [31:0] reg_wdata, reg_rdata, d, x;
   logic [7:0]  ra [5] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'hF0};
   logic [31:0] rv [5] = '{32'h0, 32'h9, 32'h13, 32'h0400, 32'h0};
   int          miscompares = 0, samples_checked = 0, pc = 0, ec = 0, sc = 0, esc = 0;
   fpe_seq #(.CYC_PER_US(2), .P_MAX_US(10), .E_MAX_US(20),
      .N_PROG(3), .N_ERASE(3)) dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .flash_write_enable_bit, .program_setup_bit, .program_pulse_bit,
      .program_verify_bit, .erase_setup_bit, .erase_pulse_bit, .erase_verify_bit,
      .flash_wr, .flash_rd, .flash_addr, .flash_wdata, .flash_rdata);
   fpe_flash_model fm (.core_clk, .bad, .ver(program_verify_bit | erase_verify_bit),
      .erase(erase_pulse_bit), .wr(flash_wr), .rd(flash_rd), .addr(flash_addr),
      .wdata(flash_wdata), .rdata(flash_rdata));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task test_done;
      $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // Start, poll busy under a bound, then check verdict and rounds
   task run(input logic [31:0] go, input logic [2:0] st, input int rounds);
      wr(8'h00, go);
      d = 32'h1;
      for (int i = 0; i < 3000 && d[0] !== 1'b0; i++) rd(8'h04);
      if (d[0] !== 1'b0) begin
         miscompares++;
         test_done();
      end
      `CHK(d[2:0], st)
      `CHK(d[25:16], 10'(rounds))
      `CHK(flash_write_enable_bit, 1'b0)
   endtask : run
   // Pulse lengths and setup lead measured on the pins
   always @(posedge core_clk) begin
      pc <= program_pulse_bit ? pc + 1 : 0;
      ec <= erase_pulse_bit ? ec + 1 : 0;
      sc <= program_setup_bit ? sc + 1 : 0;
      esc <= erase_setup_bit ? esc + 1 : 0;
      if (pc > 20 || ec > 40) `CHK(pc + ec, 0)
      if (program_pulse_bit && pc == 0) `CHK(sc >= fpe_pkg::T_PSU_US * 2, 1'b1)
      if (erase_pulse_bit && ec == 0) `CHK(esc >= fpe_pkg::T_ESU_US * 2, 1'b1)
      // Every setup or verify level needs write enable under it
      if (program_setup_bit | erase_setup_bit | program_verify_bit | erase_verify_bit)
         `CHK(flash_write_enable_bit, 1'b1)
   end
   initial begin
      rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
      reg_wdata = 32'h0; bad = 1'b0; x = 32'd72;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      foreach (ra[i]) begin
         rd(ra[i]);
         `CHK(d, rv[i])
      end
      wr(8'hF0, 32'hFFFF_FFFF);
      rd(8'hF0);
      `CHK(d, 32'h0)
      wr(8'h08, 32'h0000_0100);
      wr(8'h14, 32'h0000_0020);
      run(32'h2, 3'b010, 1);
      foreach (fm.mem[i]) `CHK(fm.mem[i], 8'hFF)
      for (int i = 0; i < 8; i++) begin
         x = xs(x);
         wr(8'(8'h20 + 4 * i), x);
         for (int j = 0; j < 4; j++) exp_q[4 * i + j] = x[8 * j +: 8];
      end
      run(32'h3, 3'b010, 1);
      foreach (exp_q[i]) `CHK(fm.mem[i], exp_q[i])
      bad <= 1'b1;
      run(32'h1, 3'b100, 3);
      run(32'h2, 3'b100, 3);
      test_done();
   end
endmodule : tb_top
